// ===== rtl/pmcs_map.vh
// register indices, field positions and reset values of the power mode and clock select block
`ifndef PMCS_MAP_VH
`define PMCS_MAP_VH

// register word indices, byte address is four times the index
`define PMCS_IDX_PWR 10'h087
`define PMCS_IDX_DIV 10'h095
`define PMCS_IDX_IRQM 10'h060
`define PMCS_IDX_WDG 10'h061
`define PMCS_IDX_BOOT 10'h062
`define PMCS_IDX_STAT 10'h063

// power_ctrl_reg fields
`define PMCS_PWR_SLEEP 0
`define PMCS_PWR_PDOWN 1

// irq_mask_reg fields
`define PMCS_IRQM_EXT_LO 0
`define PMCS_IRQM_BOD 6
`define PMCS_IRQM_GATE 7

// wdog_ctrl_reg fields
`define PMCS_WDG_RUN 0

// clock_boot_config fields
`define PMCS_CFG_SRC_LO 0
`define PMCS_CFG_SRC_HI 1
`define PMCS_CFG_RCFS 3
`define PMCS_CFG_FILT 4
`define PMCS_CFG_WDOFF 7

// reset values
`define PMCS_RST_DIV 8'h00
`define PMCS_RST_BOOT 8'hff
`define PMCS_RST_IRQM 8'h00

// bus answers
`define PMCS_RESP_OK 2'h0
`define PMCS_RESP_ERR 2'h2
`endif

// ===== rtl/pmcs_top.v
// power mode and clock select control with an axi4-lite register slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pmcs_map.vh"

// Overview of operation
// - sleep holds program counter, registers keep contents
// - sleep freezes port pins at entry levels
// - peripheral clocks keep running during sleep
// - writing sleep request bit enters sleep
// - enabled interrupt clears sleep bit, runs service
// - non-software resets also end sleep
// - power-down stops system clock entirely
// - writing power-down request bit enters power-down
// - power-down keeps ram and port latches
// - non-software resets end power-down; brownout conditional
// - pin or power-on reset restarts from vector
// - enabled external pin with gate wakes clock
// - interrupt wake runs service then resumes
// - brownout interrupt wakes if detector stays enabled
// - rc frequency bit one bypasses divide-by-two
// - filter bit enables oscillator input filter
// - watchdog run bit loads inverse boot bit
// - eight-bit clock divider register, resets zero
// - power-down bit cleared by hardware on wake
// - both bits set gives power-down only
// - watchdog counter cleared on entry and wake
module pmcs_top #(
   parameter EXT_PINS = 2,
   parameter INT_SRCS = 4
) (
   // clock and reset
   input wire clk_sys,
   input wire rstn,
   // axi4-lite write address and data
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // boot configuration byte and brownout detector status
   input wire [7:0] cfg_boot,
   input wire bod_det_en,
   input wire bod_irq,
   // interrupt sources
   input wire [EXT_PINS-1:0] ext_irq_pin,
   input wire [INT_SRCS-1:0] irq_src,
   // reset source events, one cycle each
   input wire rst_pin_evt,
   input wire rst_por_evt,
   input wire rst_bod_evt,
   input wire rst_sw_evt,
   // power state controls
   output reg cpu_hold,
   output reg port_hold,
   output reg periph_clk_en,
   output reg sys_clk_en,
   output reg wdog_clear,
   output reg cpu_restart,
   output reg wake_irq,
   // clock source controls
   output reg clk_src_rc,
   output reg clk_src_ext,
   output reg clk_src_xtal,
   output reg rc_div2_bypass,
   output reg input_clk_filter_en,
   output reg wdog_run_bit,
   output reg [7:0] clock_divider
);

   // power states and top bit index of the interrupt vector
   localparam ST_RUN = 2'b00;
   localparam ST_SLEEP = 2'b01;
   localparam ST_PDOWN = 2'b10;
   localparam NIRQ = EXT_PINS + INT_SRCS;

   // state, request, configuration and bus capture registers
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg sleep_req_q;
   reg pdown_req_q;
   reg bod_entry_q;
   reg [7:0] irq_mask_q;
   reg [7:0] boot_cfg_q;
   reg cfg_taken_q;
   reg aw_got_q;
   reg w_got_q;
   reg [9:0] aw_idx_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg [EXT_PINS-1:0] ext_s1_q;
   reg [EXT_PINS-1:0] ext_s2_q;
   reg [EXT_PINS-1:0] ext_s3_q;
   reg [EXT_PINS-1:0] ext_lvl_q;
   reg [31:0] rd_d;
   reg rd_ok;

   // wake decisions and write strobes
   wire do_wr;
   wire [NIRQ:0] irq_vec;
   wire gate;
   wire sleep_wake;
   wire pd_wake;
   wire rst_wake;
   wire irq_wake;
   wire any_rst;
   wire wr_pwr;
   wire wr_ok;
   wire [7:0] boot_now;

   // external pins pass three flops, a change counts when the last two agree
   always @(posedge clk_sys) begin
      if (!rstn) begin
         ext_s1_q <= {EXT_PINS{1'b0}};
         ext_s2_q <= {EXT_PINS{1'b0}};
         ext_s3_q <= {EXT_PINS{1'b0}};
         ext_lvl_q <= {EXT_PINS{1'b0}};
      end else begin
         ext_s1_q <= ext_irq_pin;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         // hold the level while flops two and three disagree, so a one-cycle glitch is dropped
         ext_lvl_q <= (ext_lvl_q & (ext_s2_q ^ ext_s3_q)) | (ext_s3_q & ~(ext_s2_q ^ ext_s3_q));
      end
   end

   // wake decisions
   assign irq_vec = {bod_irq, irq_src, ext_lvl_q};
   assign gate = irq_mask_q[`PMCS_IRQM_GATE];
   assign sleep_wake = gate && |(irq_vec & irq_mask_q[NIRQ:0]);
   assign pd_wake = gate && (|(ext_lvl_q & irq_mask_q[EXT_PINS-1:0]) ||
      (bod_irq && irq_mask_q[`PMCS_IRQM_BOD] && bod_det_en && bod_entry_q));
   assign rst_wake = rst_pin_evt || rst_por_evt ||
      (rst_bod_evt && (state_q != ST_PDOWN || bod_entry_q));
   assign irq_wake = (state_q == ST_SLEEP && sleep_wake) || (state_q == ST_PDOWN && pd_wake);
   assign any_rst = rst_pin_evt || rst_por_evt || rst_bod_evt || rst_sw_evt;

   // power state machine
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (pdown_req_q)
               state_d = ST_PDOWN;
            else if (sleep_req_q)
               state_d = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (rst_wake || sleep_wake)
               state_d = ST_RUN;
         end
         ST_PDOWN: begin
            if (rst_wake || pd_wake)
               state_d = ST_RUN;
         end
         default: state_d = ST_RUN;
      endcase
   end

   // state register; detector enable remembered on entry to power-down
   always @(posedge clk_sys) begin
      if (!rstn) begin
         state_q <= ST_RUN;
         bod_entry_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_RUN && state_d == ST_PDOWN)
            bod_entry_q <= bod_det_en;
      end
   end

   // request bits: hardware clears on wake, a write in the same cycle wins
   assign wr_pwr = do_wr && aw_idx_q == `PMCS_IDX_PWR && wstrb_q[0];
   always @(posedge clk_sys) begin
      if (!rstn) begin
         sleep_req_q <= 1'b0;
         pdown_req_q <= 1'b0;
      end else begin
         if (state_q != ST_RUN && state_d == ST_RUN) begin
            sleep_req_q <= 1'b0;
            pdown_req_q <= 1'b0;
         end
         if (wr_pwr) begin
            sleep_req_q <= wdata_q[`PMCS_PWR_SLEEP];
            pdown_req_q <= wdata_q[`PMCS_PWR_PDOWN];
         end
      end
   end

   // gating outputs and wake pulses
   // outputs are registered from the next state so they switch together with state_q
   always @(posedge clk_sys) begin
      if (!rstn) begin
         cpu_hold <= 1'b0;
         port_hold <= 1'b0;
         periph_clk_en <= 1'b1;
         sys_clk_en <= 1'b1;
         wdog_clear <= 1'b0;
         cpu_restart <= 1'b0;
         wake_irq <= 1'b0;
      end else begin
         cpu_hold <= state_d != ST_RUN;
         port_hold <= state_d != ST_RUN;
         periph_clk_en <= state_d != ST_PDOWN;
         sys_clk_en <= state_d != ST_PDOWN;
         wdog_clear <= state_d != state_q;
         cpu_restart <= state_q != ST_RUN && rst_wake && (rst_pin_evt || rst_por_evt);
         wake_irq <= irq_wake && !rst_wake;
      end
   end

   // boot configuration capture and clock source decode
   // decode the live byte in the capture cycle so the source never flips after reset
   assign boot_now = cfg_taken_q ? boot_cfg_q : cfg_boot;
   always @(posedge clk_sys) begin
      if (!rstn) begin
         boot_cfg_q <= `PMCS_RST_BOOT;
         cfg_taken_q <= 1'b0;
         clk_src_rc <= 1'b0;
         clk_src_ext <= 1'b0;
         clk_src_xtal <= 1'b0;
         rc_div2_bypass <= 1'b0;
         input_clk_filter_en <= 1'b0;
      end else begin
         if (!cfg_taken_q) begin
            boot_cfg_q <= cfg_boot;
            cfg_taken_q <= 1'b1;
         end
         clk_src_rc <= boot_now[`PMCS_CFG_SRC_HI] && boot_now[`PMCS_CFG_SRC_LO];
         clk_src_ext <= boot_now[`PMCS_CFG_SRC_HI] && !boot_now[`PMCS_CFG_SRC_LO];
         clk_src_xtal <= !boot_now[`PMCS_CFG_SRC_HI];
         rc_div2_bypass <= boot_now[`PMCS_CFG_RCFS];
         input_clk_filter_en <= boot_now[`PMCS_CFG_FILT];
      end
   end

   // software registers: divider, interrupt mask, watchdog run bit
   // a reset event in the same cycle as a write to the run bit wins
   assign wr_ok = do_wr && wstrb_q[0];
   always @(posedge clk_sys) begin
      if (!rstn) begin
         clock_divider <= `PMCS_RST_DIV;
         irq_mask_q <= `PMCS_RST_IRQM;
         wdog_run_bit <= 1'b0;
      end else begin
         if (wr_ok && aw_idx_q == `PMCS_IDX_DIV)
            clock_divider <= wdata_q[7:0];
         if (wr_ok && aw_idx_q == `PMCS_IDX_IRQM)
            irq_mask_q <= wdata_q[7:0];
         if (wr_ok && aw_idx_q == `PMCS_IDX_WDG)
            wdog_run_bit <= wdata_q[`PMCS_WDG_RUN];
         if (!cfg_taken_q)
            wdog_run_bit <= !cfg_boot[`PMCS_CFG_WDOFF];
         else if (any_rst)
            wdog_run_bit <= !boot_cfg_q[`PMCS_CFG_WDOFF];
      end
   end

   // write channel: address and data taken in either order, then one response
   // lane 0 strobe low still answers okay; unmapped words answer with an error
   assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
   always @(posedge clk_sys) begin
      if (!rstn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMCS_RESP_OK;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_idx_q <= 10'h000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         s_axi_awready <= !s_axi_awready && s_axi_awvalid && !aw_got_q && !s_axi_bvalid;
         s_axi_wready <= !s_axi_wready && s_axi_wvalid && !w_got_q && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[11:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_idx_q == `PMCS_IDX_PWR || aw_idx_q == `PMCS_IDX_DIV ||
                            aw_idx_q == `PMCS_IDX_IRQM || aw_idx_q == `PMCS_IDX_WDG ||
                            aw_idx_q == `PMCS_IDX_BOOT || aw_idx_q == `PMCS_IDX_STAT) ?
                           `PMCS_RESP_OK : `PMCS_RESP_ERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read data mux, unmapped words answer with an error and zero data
   always @* begin
      rd_d = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr[11:2])
         `PMCS_IDX_PWR: rd_d[1:0] = {pdown_req_q, sleep_req_q};
         `PMCS_IDX_DIV: rd_d[7:0] = clock_divider;
         `PMCS_IDX_IRQM: rd_d[7:0] = irq_mask_q;
         `PMCS_IDX_WDG: rd_d[0] = wdog_run_bit;
         `PMCS_IDX_BOOT: rd_d[7:0] = boot_cfg_q;
         `PMCS_IDX_STAT: rd_d[3:0] = {cfg_taken_q, bod_entry_q, state_q};
         default: rd_ok = 1'b0;
      endcase
   end

   // read channel
   always @(posedge clk_sys) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PMCS_RESP_OK;
      end else begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_ok ? `PMCS_RESP_OK : `PMCS_RESP_ERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // pmcs_top

// ===== bench/pmcs_checker.sv
// concurrent checks on the power mode and clock select outputs
`timescale 1ns/1ps
module pmcs_checker (
   // clock and reset
   input wire clk_sys,
   input wire rstn,
   // boot byte
   input wire [7:0] cfg_boot,
   // power state outputs
   input wire cpu_hold,
   input wire port_hold,
   input wire sys_clk_en,
   input wire wdog_clear,
   input wire cpu_restart,
   input wire wake_irq,
   // clock source outputs
   input wire clk_src_rc,
   input wire clk_src_ext,
   input wire clk_src_xtal,
   input wire rc_div2_bypass,
   input wire input_clk_filter_en,
   input wire wdog_run_bit
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_pdown_cpu_frozen: assert property (!sys_clk_en |-> cpu_hold)
      else $error("clock stopped while cpu runs");
   a_port_hold_track: assert property (port_hold == cpu_hold)
      else $error("port hold differs from cpu hold");
   a_wdog_clear_edge: assert property ($changed(cpu_hold) |-> wdog_clear)
      else $error("state change without watchdog clear");
   a_irq_wake_exit: assert property (wake_irq |-> !cpu_hold && $past(cpu_hold))
      else $error("interrupt wake without leaving low power");
   a_restart_exit: assert property (cpu_restart |-> !cpu_hold && $past(cpu_hold))
      else $error("restart without leaving low power");
   a_src_onehot: assert property ($past(rstn, 3) |-> $onehot({clk_src_rc, clk_src_ext, clk_src_xtal}))
      else $error("clock source not one-hot");
   a_boot_stable: assert property ($past(rstn, 3) |->
      $stable({clk_src_rc, clk_src_ext, clk_src_xtal, rc_div2_bypass, input_clk_filter_en}))
      else $error("boot clock bits changed");
   a_wdog_boot_load: assert property (!$past(rstn) |=> wdog_run_bit == !$past(cfg_boot[7]))
      else $error("watchdog run bit not loaded");
endmodule // pmcs_checker

bind pmcs_top pmcs_checker chk_i (.*);

// ===== bench/tb_top.sv
// self-checking bench for the power mode and clock select block
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 0, rstn = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 4'hf, irq_src = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [7:0] cfg_boot = 8'h7b;
   logic bod_det_en = 0, bod_irq = 0, rst_pin_evt = 0, rst_por_evt = 0, rst_bod_evt = 0, rst_sw_evt = 0;
   logic [1:0] ext_irq_pin = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire cpu_hold, port_hold, periph_clk_en, sys_clk_en, wdog_clear, cpu_restart, wake_irq;
   wire clk_src_rc, clk_src_ext, clk_src_xtal, rc_div2_bypass, input_clk_filter_en, wdog_run_bit;
   wire [7:0] clock_divider;
   int err_count = 0, checks_done = 0, cyc = 0;
   // rows: address, byte written, byte read back, response
   logic [29:0] rows [7] = '{{12'h254, 8'ha5, 8'ha5, 2'h0}, {12'h180, 8'h5a, 8'h5a, 2'h0},
      {12'h254, 8'hff, 8'hff, 2'h0}, {12'h3fc, 8'hff, 8'h00, 2'h2}, {12'h184, 8'h00, 8'h00, 2'h0},
      {12'h188, 8'h00, 8'h7b, 2'h0}, {12'h18c, 8'hff, 8'h08, 2'h0}};
   logic [7:0] cfgs [3] = '{8'h80, 8'h72, 8'h7b};

   pmcs_top dut (
      .clk_sys(clk_sys), .rstn(rstn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .cfg_boot(cfg_boot), .bod_det_en(bod_det_en), .bod_irq(bod_irq),
      .ext_irq_pin(ext_irq_pin), .irq_src(irq_src),
      .rst_pin_evt(rst_pin_evt), .rst_por_evt(rst_por_evt), .rst_bod_evt(rst_bod_evt), .rst_sw_evt(rst_sw_evt),
      .cpu_hold(cpu_hold), .port_hold(port_hold), .periph_clk_en(periph_clk_en), .sys_clk_en(sys_clk_en),
      .wdog_clear(wdog_clear), .cpu_restart(cpu_restart), .wake_irq(wake_irq),
      .clk_src_rc(clk_src_rc), .clk_src_ext(clk_src_ext), .clk_src_xtal(clk_src_xtal),
      .rc_div2_bypass(rc_div2_bypass), .input_clk_filter_en(input_clk_filter_en),
      .wdog_run_bit(wdog_run_bit), .clock_divider(clock_divider)
   );

   always #2.5 clk_sys = ~clk_sys;

   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         tally_and_finish;
      end
   end

   task tk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task wr(input [11:0] a, input [7:0] d, input [1:0] r);
      tk(1);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         tk(1);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk(s_axi_bresp, r);
   endtask

   task rd(input [11:0] a, input [7:0] e, input [1:0] r);
      tk(1);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         tk(1);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, {24'h0, e});
      chk(s_axi_rresp, r);
   endtask

   task rst(input [7:0] c);
      cfg_boot <= c;
      rstn <= 0;
      tk(20);
      rstn <= 1;
      tk(4);
   endtask

   task tally_and_finish;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      logic [7:0] c;
      rst(8'h7b);
      rd(12'h254, 0, 0);
      foreach (rows[i]) begin
         wr(rows[i][29:18], rows[i][17:10], rows[i][1:0]);
         rd(rows[i][29:18], rows[i][9:2], rows[i][1:0]);
      end
      chk(clock_divider, 8'hff);
      // every clock source, filter and watchdog boot value
      foreach (cfgs[i]) begin
         c = cfgs[i];
         rst(c);
         chk({clk_src_rc, clk_src_ext, clk_src_xtal, rc_div2_bypass, input_clk_filter_en, wdog_run_bit},
            {c[1] & c[0], c[1] & ~c[0], ~c[1], c[3], c[4], ~c[7]});
         rd(12'h188, c, 0);
      end
      // sleep: unmasked line ignored, masked line wakes; mask bit 4 is irq_src[2]
      wr(12'h180, 8'h90, 0);
      wr(12'h21c, 8'h01, 0);
      tk(3);
      chk({cpu_hold, port_hold, sys_clk_en, periph_clk_en}, 4'hf);
      irq_src <= 4'h8;
      tk(5);
      chk(cpu_hold, 1);
      irq_src <= 4'hc;
      while (!wake_irq) tk(1);
      chk(cpu_hold, 0);
      chk(wdog_clear, 1);
      irq_src <= 0;
      rd(12'h21c, 0, 0);
      // sleep ended by a power-on reset event
      wr(12'h21c, 8'h01, 0);
      tk(3);
      chk(cpu_hold, 1);
      rst_por_evt <= 1;
      tk(1);
      rst_por_evt <= 0;
      while (!cpu_restart) tk(1);
      chk(cpu_hold, 0);
      rd(12'h21c, 0, 0);
      // power-down: software reset ignored, pin wakes
      wr(12'h180, 8'h81, 0);
      wr(12'h21c, 8'h02, 0);
      tk(3);
      chk({cpu_hold, sys_clk_en, periph_clk_en}, 3'h4);
      rst_sw_evt <= 1;
      rst_bod_evt <= 1; // detector was off at entry, so no wake
      tk(1);
      rst_sw_evt <= 0;
      rst_bod_evt <= 0;
      tk(5);
      chk(cpu_hold, 1);
      ext_irq_pin <= 2'h1;
      while (!wake_irq) tk(1);
      ext_irq_pin <= 0;
      rd(12'h21c, 0, 0);
      // both requests, pin reset wakes with no sleep after
      wr(12'h21c, 8'h03, 0);
      tk(3);
      chk({cpu_hold, sys_clk_en}, 2'h2);
      rst_pin_evt <= 1;
      tk(1);
      rst_pin_evt <= 0;
      while (!cpu_restart) tk(1);
      tk(3);
      chk(cpu_hold, 0);
      rd(12'h21c, 0, 0);
      // brownout line wakes power-down with detector kept on
      bod_det_en <= 1;
      wr(12'h180, 8'hc0, 0);
      wr(12'h21c, 8'h02, 0);
      tk(3);
      chk({cpu_hold, sys_clk_en}, 2'h2);
      bod_irq <= 1;
      while (!wake_irq) tk(1);
      bod_irq <= 0;
      chk(sys_clk_en, 1);
      tally_and_finish;
   end
endmodule // tb_top
